//--- hw/iic_top.sv
// IEEE-488 interface control: standby, parallel poll, local, online, addressing.
`default_nettype none
module iic_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] dio_in,
	output logic [7:0] dio_out,
	output logic [7:0] dio_oe,
	input wire logic atn_in,
	output logic atn_out,
	input wire logic eoi_in,
	output logic eoi_out,
	input wire logic dav_in,
	output logic dav_out,
	output logic nrfd_out,
	output logic ndac_out,
	input wire logic ren_in,
	output logic remote_lockout_flag,
	output logic rtl_pulse
);
	////////////////////////////////////////////////////////////////////////
	// State
	logic online_reg, cic_reg, active_reg, shadow_reg, holdoff_reg;
	logic ist_reg, ppe_valid_reg, sense_reg, lockout_reg, remote_reg, lacs_reg;
	logic [2:0] line_reg;
	logic [4:0] pad_reg, sad_reg;
	logic sad_en_reg;
	logic [15:0] eos_reg;
	logic [31:0] result_reg;
	logic [1:0] err_reg;
	logic [7:0] cmd_byte_reg;
	logic cmd_vld_reg;
	logic acc_reg, dav_d_reg, rtl_reg;
	logic ppc_seen_reg;
	iic_pkg::iic_seq_t seq_reg, seq_next;
	logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg, awready_reg, wready_reg, arready_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [1:0] bresp_reg, rresp_reg;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write and read paths
	wire aw_take = s_axi_awvalid && awready_reg;
	wire w_take = s_axi_wvalid && wready_reg;
	wire [7:0] wa = aw_take ? s_axi_awaddr : awaddr_reg;
	wire [31:0] wd = w_take ? s_axi_wdata : wdata_reg;
	wire wr_fire = (aw_got_reg || aw_take) && (w_got_reg || w_take) && !bvalid_reg;
	wire aw_got_next = wr_fire ? 1'b0 : (aw_got_reg || aw_take);
	wire w_got_next = wr_fire ? 1'b0 : (w_got_reg || w_take);
	wire bvalid_next = wr_fire || (bvalid_reg && !s_axi_bready);
	wire rd_take = s_axi_arvalid && arready_reg;
	wire rvalid_next = rd_take || (rvalid_reg && !s_axi_rready);
	wire wr_cmd = wr_fire && wa == iic_pkg::OFF_CMD;
	wire wr_arg = wr_fire && wa == iic_pkg::OFF_ARG;
	wire wr_ok = wr_cmd || wr_arg;
	logic [31:0] arg_reg;
	wire [3:0] cmd = wd[3:0];
	wire do_cmd = wr_cmd && online_reg;
	wire do_online = wr_cmd && cmd == iic_pkg::CMD_ONLINE;

	// Bus command decode while ATN is asserted by the controller
	wire atn_cmd = atn_in && !active_reg;
	wire [7:0] bus_byte = dio_in;
	wire dav_rise = dav_in && !dav_d_reg;
	wire bus_cmd = online_reg && atn_cmd && dav_rise;
	wire [7:0] my_listen = iic_pkg::LISTEN_BASE + {3'h0, pad_reg};
	wire [7:0] my_talk = iic_pkg::TALK_BASE + {3'h0, pad_reg};
	wire hit_listen = bus_cmd && bus_byte == my_listen;
	wire hit_unl = bus_cmd && bus_byte == iic_pkg::BYTE_UNL;
	wire hit_gtl = bus_cmd && bus_byte == iic_pkg::BYTE_GTL && lacs_reg;
	wire is_ppe = bus_byte[7:4] == iic_pkg::PPE_BASE[7:4];
	wire hit_ppe = bus_cmd && lacs_reg && ppc_seen_reg && is_ppe;
	wire hit_ppd = bus_cmd && lacs_reg && ppc_seen_reg && bus_byte == iic_pkg::PPD_CMD;

	// End detection during shadow handshake
	wire eos_8 = eos_reg[iic_pkg::EOS_8BIT_BIT];
	wire eos_on = eos_reg[iic_pkg::EOS_READ_BIT];
	wire eos_hit = eos_on && (eos_8 ? bus_byte == eos_reg[7:0] :
		bus_byte[6:0] == eos_reg[6:0]);
	wire data_byte = online_reg && shadow_reg && !active_reg && !atn_in && dav_rise;
	wire end_seen = data_byte && (eoi_in || eos_hit);

	wire idy = atn_in && eoi_in && !active_reg;
	wire poll_drive = online_reg && ppe_valid_reg && idy;
	wire [7:0] poll_mask = 8'h01 << line_reg;
	wire poll_level = ~(ist_reg ^ sense_reg);

	wire pad_bad = arg_reg[4:0] > iic_pkg::PAD_MAX;
	wire seq_step = seq_reg != iic_pkg::IIC_SEQ_IDLE;

	////////////////////////////////////////////////////////////////////////
	// Go-local command sequence toward an instrument
	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			iic_pkg::IIC_SEQ_IDLE: seq_next = iic_pkg::IIC_SEQ_IDLE;
			iic_pkg::IIC_SEQ_UNL1: seq_next = iic_pkg::IIC_SEQ_LAD;
			iic_pkg::IIC_SEQ_LAD: seq_next = sad_en_reg ? iic_pkg::IIC_SEQ_SAD :
				iic_pkg::IIC_SEQ_GTL;
			iic_pkg::IIC_SEQ_SAD: seq_next = iic_pkg::IIC_SEQ_GTL;
			iic_pkg::IIC_SEQ_GTL: seq_next = iic_pkg::IIC_SEQ_UNT;
			iic_pkg::IIC_SEQ_UNT: seq_next = iic_pkg::IIC_SEQ_UNL2;
			iic_pkg::IIC_SEQ_UNL2: seq_next = iic_pkg::IIC_SEQ_IDLE;
			default: seq_next = iic_pkg::IIC_SEQ_IDLE;
		endcase
	end
	logic [7:0] seq_byte;
	always_comb begin
		seq_byte = 8'h00;
		case (seq_reg)
			iic_pkg::IIC_SEQ_UNL1: seq_byte = iic_pkg::BYTE_UNL;
			iic_pkg::IIC_SEQ_LAD: seq_byte = iic_pkg::LISTEN_BASE + {3'h0, arg_reg[4:0]};
			iic_pkg::IIC_SEQ_SAD: seq_byte = iic_pkg::PPE_BASE + {3'h0, sad_reg};
			iic_pkg::IIC_SEQ_GTL: seq_byte = iic_pkg::BYTE_GTL;
			iic_pkg::IIC_SEQ_UNT: seq_byte = iic_pkg::BYTE_UNT;
			iic_pkg::IIC_SEQ_UNL2: seq_byte = iic_pkg::BYTE_UNL;
			default: seq_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Interface control state
	always_ff @(posedge aclk) begin
		if (!aresetn || (do_online && wd[4 +: 28] == 28'h0) || !online_reg && !do_online) begin
			online_reg <= !aresetn ? 1'b1 : 1'b0;
			cic_reg <= 1'b0;
			active_reg <= 1'b0;
			shadow_reg <= 1'b0;
			holdoff_reg <= 1'b0;
			ist_reg <= 1'b0;
			ppe_valid_reg <= 1'b0;
			sense_reg <= 1'b0;
			line_reg <= 3'h0;
			lockout_reg <= 1'b0;
			remote_reg <= 1'b0;
			lacs_reg <= 1'b0;
			ppc_seen_reg <= 1'b0;
			pad_reg <= iic_pkg::PAD_RESET;
			eos_reg <= iic_pkg::EOS_RESET;
			seq_reg <= iic_pkg::IIC_SEQ_IDLE;
			err_reg <= iic_pkg::ERR_NONE;
			result_reg <= 32'h0;
			rtl_reg <= 1'b0;
		end else if (do_online) begin
			online_reg <= 1'b1;
			cic_reg <= 1'b0;
			active_reg <= 1'b0;
			shadow_reg <= 1'b0;
			holdoff_reg <= 1'b0;
			ist_reg <= 1'b0;
			ppe_valid_reg <= 1'b0;
			pad_reg <= iic_pkg::PAD_RESET;
			eos_reg <= iic_pkg::EOS_RESET;
			seq_reg <= iic_pkg::IIC_SEQ_IDLE;
			err_reg <= iic_pkg::ERR_NONE;
			rtl_reg <= 1'b0;
		end else begin
			rtl_reg <= 1'b0;
			seq_reg <= seq_next;
			lacs_reg <= hit_listen ? 1'b1 : (hit_unl ? 1'b0 : lacs_reg);
			ppc_seen_reg <= bus_cmd ? (bus_byte == iic_pkg::BYTE_PPC) : ppc_seen_reg;
			if (hit_gtl)
				remote_reg <= 1'b0;
			else if (hit_listen && ren_in)
				remote_reg <= 1'b1;
			if (bus_cmd && bus_byte == iic_pkg::BYTE_LLO)
				lockout_reg <= 1'b1;
			if (!ren_in) begin
				lockout_reg <= 1'b0;
				remote_reg <= 1'b0;
			end
			if (hit_ppe) begin
				line_reg <= bus_byte[2:0];
				sense_reg <= bus_byte[3];
				ppe_valid_reg <= 1'b1;
			end else if (hit_ppd)
				ppe_valid_reg <= 1'b0;
			if (end_seen)
				holdoff_reg <= 1'b1;
			if (do_cmd) begin
				err_reg <= iic_pkg::ERR_NONE;
				case (cmd)
					iic_pkg::CMD_GO_STANDBY: begin
						if (!cic_reg)
							err_reg <= iic_pkg::ERR_NOT_CONTROLLER;
						else begin
							active_reg <= 1'b0;
							shadow_reg <= arg_reg != 32'h0;
							holdoff_reg <= 1'b0;
						end
					end
					iic_pkg::CMD_TAKE_CONTROL: begin
						cic_reg <= 1'b1;
						active_reg <= 1'b1;
						shadow_reg <= 1'b0;
						holdoff_reg <= 1'b0;
					end
					iic_pkg::CMD_SET_IST: begin
						ist_reg <= arg_reg != 32'h0;
						result_reg <= {31'h0, ist_reg};
					end
					iic_pkg::CMD_LOCAL_PPE: begin
						line_reg <= arg_reg[2:0];
						sense_reg <= arg_reg[3];
						ppe_valid_reg <= arg_reg[7:4] == iic_pkg::PPE_BASE[7:4];
					end
					iic_pkg::CMD_GO_LOCAL: begin
						if (!lockout_reg) begin
							rtl_reg <= 1'b1;
							remote_reg <= 1'b0;
						end
					end
					iic_pkg::CMD_GTL_SEQ: begin
						if (!cic_reg || !active_reg)
							err_reg <= iic_pkg::ERR_NOT_CONTROLLER;
						else begin
							seq_reg <= iic_pkg::IIC_SEQ_UNL1;
							sad_reg <= arg_reg[12:8];
							sad_en_reg <= arg_reg[15];
						end
					end
					iic_pkg::CMD_SET_PAD: begin
						if (pad_bad)
							err_reg <= iic_pkg::ERR_BAD_ARGUMENT;
						else begin
							pad_reg <= arg_reg[4:0];
							result_reg <= {27'h0, pad_reg};
						end
					end
					iic_pkg::CMD_SET_EOS: begin
						eos_reg <= arg_reg[15:0];
						result_reg <= {16'h0, eos_reg};
					end
					default: err_reg <= iic_pkg::ERR_BAD_ARGUMENT;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Argument latch, handshake tracking and outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arg_reg <= 32'h0;
			dav_d_reg <= 1'b0;
			acc_reg <= 1'b0;
			dio_out <= 8'h00;
			dio_oe <= 8'h00;
			atn_out <= 1'b0;
			eoi_out <= 1'b0;
			dav_out <= 1'b0;
			nrfd_out <= 1'b0;
			ndac_out <= 1'b0;
			remote_lockout_flag <= 1'b0;
			rtl_pulse <= 1'b0;
		end else begin
			if (wr_arg)
				arg_reg <= wd;
			dav_d_reg <= dav_in;
			acc_reg <= data_byte ? 1'b1 : (!dav_in ? 1'b0 : acc_reg);
			atn_out <= online_reg && active_reg;
			dav_out <= online_reg && seq_step;
			eoi_out <= 1'b0;
			// Shadow acceptor: NDAC released once a byte is seen, NRFD held after END
			nrfd_out <= online_reg && shadow_reg && (holdoff_reg || end_seen);
			ndac_out <= online_reg && shadow_reg && !acc_reg && !data_byte;
			if (poll_drive) begin
				dio_oe <= poll_mask;
				dio_out <= poll_level ? poll_mask : 8'h00;
			end else if (online_reg && seq_step) begin
				dio_oe <= 8'hff;
				dio_out <= seq_byte;
			end else begin
				dio_oe <= 8'h00;
				dio_out <= 8'h00;
			end
			remote_lockout_flag <= lockout_reg;
			rtl_pulse <= rtl_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshake registers
	logic [31:0] rd_mux;
	always_comb begin
		case (s_axi_araddr)
			iic_pkg::OFF_ARG: rd_mux = arg_reg;
			iic_pkg::OFF_RESULT: rd_mux = result_reg;
			iic_pkg::OFF_STATUS: rd_mux = {22'h0, remote_reg, lockout_reg, holdoff_reg,
				shadow_reg, active_reg, cic_reg, online_reg, err_reg, ist_reg};
			iic_pkg::OFF_PPE: rd_mux = {27'h0, ppe_valid_reg, sense_reg, line_reg};
			iic_pkg::OFF_ADDR: rd_mux = {16'h0, my_talk, my_listen};
			iic_pkg::OFF_BUS: rd_mux = {20'h0, lacs_reg, seq_reg, eos_reg[7:0]};
			iic_pkg::OFF_CMD: rd_mux = 32'h0;
			default: rd_mux = 32'h0;
		endcase
	end
	wire rd_known = s_axi_araddr <= iic_pkg::OFF_ADDR && s_axi_araddr[1:0] == 2'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= iic_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= iic_pkg::RESP_OKAY;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
		end else begin
			// Readies come from next state so the bus sees only flop outputs
			awready_reg <= !aw_got_next && !bvalid_next;
			wready_reg <= !w_got_next && !bvalid_next;
			arready_reg <= !rvalid_next;
			if (aw_take) awaddr_reg <= s_axi_awaddr;
			if (w_take) wdata_reg <= s_axi_wdata;
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? iic_pkg::RESP_OKAY : iic_pkg::RESP_SLVERR;
			end else begin
				aw_got_reg <= aw_got_reg || aw_take;
				w_got_reg <= w_got_reg || w_take;
				if (bvalid_reg && s_axi_bready) bvalid_reg <= 1'b0;
			end
			if (rd_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_mux;
				rresp_reg <= rd_known ? iic_pkg::RESP_OKAY : iic_pkg::RESP_SLVERR;
			end else if (rvalid_reg && s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
endmodule
`default_nettype wire

//--- hw/iic_pkg.sv
// Package: constants for the IEEE-488 interface control block.
`default_nettype none
package iic_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_ARG = 8'h04;
	localparam logic [7:0] OFF_RESULT = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_BUS = 8'h10;
	localparam logic [7:0] OFF_PPE = 8'h14;
	localparam logic [7:0] OFF_ADDR = 8'h18;
	// Command codes written to OFF_CMD
	localparam logic [3:0] CMD_GO_STANDBY = 4'h1;
	localparam logic [3:0] CMD_SET_IST = 4'h2;
	localparam logic [3:0] CMD_GO_LOCAL = 4'h3;
	localparam logic [3:0] CMD_ONLINE = 4'h4;
	localparam logic [3:0] CMD_SET_PAD = 4'h5;
	localparam logic [3:0] CMD_SET_EOS = 4'h6;
	localparam logic [3:0] CMD_TAKE_CONTROL = 4'h7;
	localparam logic [3:0] CMD_LOCAL_PPE = 4'h8;
	localparam logic [3:0] CMD_GTL_SEQ = 4'h9;
	// Error codes in status register
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_NOT_CONTROLLER = 2'h1;
	localparam logic [1:0] ERR_BAD_ARGUMENT = 2'h2;
	// Bus command bytes and primary address limit
	localparam logic [7:0] BYTE_UNL = 8'h3f;
	localparam logic [7:0] BYTE_UNT = 8'h5f;
	localparam logic [7:0] BYTE_GTL = 8'h01;
	localparam logic [7:0] BYTE_PPC = 8'h05;
	localparam logic [7:0] BYTE_LLO = 8'h11;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam logic [7:0] PPE_BASE = 8'h60;
	localparam logic [7:0] PPD_CMD = 8'h70;
	localparam logic [4:0] PAD_MAX = 5'h1e;
	// Defaults
	localparam logic [4:0] PAD_RESET = 5'h00;
	localparam logic [15:0] EOS_RESET = 16'h0000;
	// Terminator config field positions
	localparam int EOS_READ_BIT = 10;
	localparam int EOS_8BIT_BIT = 12;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		IIC_SEQ_IDLE = 3'b000,
		IIC_SEQ_UNL1 = 3'b001,
		IIC_SEQ_LAD = 3'b010,
		IIC_SEQ_SAD = 3'b011,
		IIC_SEQ_GTL = 3'b100,
		IIC_SEQ_UNT = 3'b101,
		IIC_SEQ_UNL2 = 3'b110
	} iic_seq_t;
endpackage
`default_nettype wire

//--- tb/iic_top_sva.sv
// Checker for the interface control block, bound to its top module.
`default_nettype none
module iic_top_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [7:0] dio_out,
	input wire logic [7:0] dio_oe,
	input wire logic atn_in,
	input wire logic eoi_in,
	input wire logic atn_out,
	input wire logic dav_out,
	input wire logic nrfd_out,
	input wire logic ren_in,
	input wire logic remote_lockout_flag,
	input wire logic rtl_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_gtl_head;
		dio_out == iic_pkg::BYTE_UNL ##1 dio_out[7:5] == 3'b001;
	endsequence
	sequence s_gtl_tail;
		$past(dio_out, 3) == iic_pkg::BYTE_GTL ##0 $past(dio_out, 2) == iic_pkg::BYTE_UNT
			##0 $past(dio_out, 1) == iic_pkg::BYTE_UNL;
	endsequence
	a_b_hold_resp: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped before bready");
	a_poll_one_line: assert property (
		$past(atn_in && eoi_in) && !dav_out |-> $onehot0(dio_oe))
		else $error("Poll response drives more than one line");
	a_poll_quiet: assert property (
		!$past(atn_in && eoi_in) && !dav_out && !$past(dav_out) |-> dio_oe == 8'h00)
		else $error("Data lines driven outside poll and go-local");
	a_gtl_all_lines: assert property (dav_out |-> dio_oe == 8'hff)
		else $error("Command byte not driven on all lines");
	a_gtl_head: assert property ($rose(dav_out) |-> s_gtl_head)
		else $error("Go-local sequence starts wrongly");
	a_gtl_tail: assert property ($fell(dav_out) |-> s_gtl_tail)
		else $error("Go-local sequence ends wrongly");
	a_rtl_single: assert property (rtl_pulse |=> !rtl_pulse)
		else $error("Return to local longer than one cycle");
	a_rtl_unlocked: assert property (rtl_pulse |-> !remote_lockout_flag)
		else $error("Return to local while locked out");
	a_lock_ren_clear: assert property (!ren_in |-> ##[1:2] !remote_lockout_flag)
		else $error("Lockout kept with remote enable released");
	a_hold_standby: assert property (nrfd_out |-> !atn_out)
		else $error("Holdoff while attention is asserted");
endmodule
bind iic_top iic_top_sva u_iic_top_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.dio_out(dio_out), .dio_oe(dio_oe), .atn_in(atn_in), .eoi_in(eoi_in),
	.atn_out(atn_out), .dav_out(dav_out), .nrfd_out(nrfd_out), .ren_in(ren_in),
	.remote_lockout_flag(remote_lockout_flag), .rtl_pulse(rtl_pulse));
`default_nettype wire

//--- tb/iic_bus_partner.sv
// Instrument bus model: talker, controller commands, poll and remote enable.
`default_nettype none
module iic_bus_partner (
	input wire logic aclk,
	input wire logic nrfd_out,
	input wire logic ndac_out,
	input wire logic [7:0] dio_out,
	input wire logic [7:0] dio_oe,
	output wire logic [7:0] dio_in,
	output logic atn_in,
	output logic eoi_in,
	output logic dav_in,
	output logic ren_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv = 8'h00;
	initial begin
		atn_in = 1'b0;
		eoi_in = 1'b0;
		dav_in = 1'b0;
		ren_in = 1'b1;
	end
	// Wired bus: any true driver wins
	assign dio_in = drv | (dio_out & dio_oe);
	task automatic send(input logic [7:0] b, input logic e, input logic a);
		int n;
		@(posedge aclk);
		drv <= b;
		eoi_in <= e;
		atn_in <= a;
		n = 0;
		while (nrfd_out === 1'b1 && n < 8) begin
			@(posedge aclk);
			n++;
		end
		dav_in <= 1'b1;
		@(posedge aclk);
		n = 0;
		while (ndac_out !== 1'b0 && n < 8) begin
			@(posedge aclk);
			n++;
		end
		@(posedge aclk);
		dav_in <= 1'b0;
		eoi_in <= 1'b0;
		atn_in <= 1'b0;
		// Released lines must not keep looking valid
		drv <= ~b;
	endtask
	task automatic idy(input logic v);
		@(posedge aclk);
		atn_in <= v;
		eoi_in <= v;
	endtask
	task automatic set_ren(input logic v);
		@(posedge aclk);
		ren_in <= v;
	endtask
endmodule
`default_nettype wire

//--- tb/test_ieee488_interface_control.sv
// Self-checking bench for the interface control block.
`default_nettype none
module test_ieee488_interface_control;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [3:0] c; logic [31:0] arg; logic [1:0] err;
		logic [31:0] res; logic [15:0] addr; logic ist;} iic_row_t;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, atn_in, eoi_in, dav_in, ren_in;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [7:0] dio_in, dio_out, dio_oe;
	logic atn_out, eoi_out, dav_out, nrfd_out, ndac_out, lock, rtl_pulse;
	int err_total = 0, check_count = 0, rtl_n = 0;
	logic [7:0] cap[$];
	logic [7:0] gexp[2][6] = '{'{8'h3f, 8'h23, 8'h62, 8'h01, 8'h5f, 8'h3f},
		'{8'h3f, 8'h25, 8'h01, 8'h5f, 8'h3f, 8'h00}};
	iic_row_t rows[7] = '{
		'{iic_pkg::CMD_SET_IST, 32'h1, iic_pkg::ERR_NONE, 32'h0, 16'h4020, 1'b1},
		'{iic_pkg::CMD_SET_IST, 32'h5, iic_pkg::ERR_NONE, 32'h1, 16'h4020, 1'b1},
		'{iic_pkg::CMD_SET_IST, 32'h0, iic_pkg::ERR_NONE, 32'h1, 16'h4020, 1'b0},
		'{iic_pkg::CMD_SET_PAD, 32'h7, iic_pkg::ERR_NONE, 32'h0, 16'h4727, 1'b0},
		'{iic_pkg::CMD_SET_PAD, 32'h1e, iic_pkg::ERR_NONE, 32'h7, 16'h5e3e, 1'b0},
		'{iic_pkg::CMD_SET_PAD, 32'h1f, iic_pkg::ERR_BAD_ARGUMENT, 32'h0, 16'h5e3e, 1'b0},
		'{iic_pkg::CMD_GO_STANDBY, 32'h1, iic_pkg::ERR_NOT_CONTROLLER, 32'h0, 16'h5e3e, 1'b0}};
	iic_top u_iic_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
		.atn_in(atn_in), .atn_out(atn_out), .eoi_in(eoi_in), .eoi_out(eoi_out),
		.dav_in(dav_in), .dav_out(dav_out), .nrfd_out(nrfd_out), .ndac_out(ndac_out),
		.ren_in(ren_in), .remote_lockout_flag(lock), .rtl_pulse(rtl_pulse));
	iic_bus_partner u_iic_bus_partner (.aclk(aclk), .nrfd_out(nrfd_out),
		.ndac_out(ndac_out), .dio_out(dio_out), .dio_oe(dio_oe), .dio_in(dio_in),
		.atn_in(atn_in), .eoi_in(eoi_in), .dav_in(dav_in), .ren_in(ren_in));
	initial begin
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (dav_out === 1'b1) cap.push_back(dio_out);
		if (rtl_pulse === 1'b1) rtl_n <= rtl_n + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ready is sampled between edges so release lands on the taking edge
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w, b;
		b = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid === 1'b1;
			rs = bresp;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar, b;
		b = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			ar = arvalid && arready;
			b = rvalid === 1'b1;
			v = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
			if (b) rready <= 1'b0;
		end
	endtask
	task automatic cmd(input logic [3:0] c, input logic [31:0] arg);
		axw(iic_pkg::OFF_ARG, arg, r);
		axw(iic_pkg::OFF_CMD, {28'h0, c}, r);
	endtask
	task automatic poll(input logic [7:0] exp);
		u_iic_bus_partner.idy(1'b1);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(32'(dio_out & dio_oe), 32'(exp));
		u_iic_bus_partner.idy(1'b0);
		repeat (3) @(posedge aclk);
	endtask
	task automatic pin(input logic exp, input int which);
		@(negedge aclk);
		chk(32'(which == 0 ? atn_out : which == 1 ? nrfd_out : which == 2 ? lock : ndac_out),
			32'(exp));
	endtask
	task automatic summarize();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			cmd(rows[i].c, rows[i].arg);
			axr(iic_pkg::OFF_STATUS, d, r);
			chk(32'(d[2:1]), 32'(rows[i].err));
			chk(32'(d[0]), 32'(rows[i].ist));
			axr(iic_pkg::OFF_RESULT, d, r);
			if (rows[i].err == iic_pkg::ERR_NONE) chk(d, rows[i].res);
			axr(iic_pkg::OFF_ADDR, d, r);
			chk(32'(d[15:0]), 32'(rows[i].addr));
		end
		axw(8'hfc, 32'h1, r);
		chk(32'(r), 32'(iic_pkg::RESP_SLVERR));
		axr(8'hfc, d, r);
		chk({d[29:0], r}, {30'h0, iic_pkg::RESP_SLVERR});
		cmd(iic_pkg::CMD_LOCAL_PPE, 32'h64);
		axr(iic_pkg::OFF_PPE, d, r);
		chk(d, 32'h14);
		poll(8'h10);
		cmd(iic_pkg::CMD_SET_IST, 32'h1);
		poll(8'h00);
		cmd(iic_pkg::CMD_LOCAL_PPE, 32'h68);
		poll(8'h01);
		cmd(iic_pkg::CMD_LOCAL_PPE, 32'h70);
		poll(8'h00);
		u_iic_bus_partner.send(8'h3e, 1'b0, 1'b1);
		u_iic_bus_partner.send(8'h05, 1'b0, 1'b1);
		u_iic_bus_partner.send(8'h6d, 1'b0, 1'b1);
		u_iic_bus_partner.send(8'h3f, 1'b0, 1'b1);
		axr(iic_pkg::OFF_PPE, d, r);
		chk(d, 32'h1d);
		axr(iic_pkg::OFF_STATUS, d, r);
		chk(32'(d[9]), 32'h1);
		poll(8'h20);
		cmd(iic_pkg::CMD_GO_LOCAL, 32'h0);
		repeat (2) @(negedge aclk);
		chk(rtl_n, 32'h1);
		u_iic_bus_partner.send(8'h11, 1'b0, 1'b1);
		pin(1'b1, 2);
		cmd(iic_pkg::CMD_GO_LOCAL, 32'h0);
		repeat (2) @(negedge aclk);
		chk(rtl_n, 32'h1);
		u_iic_bus_partner.set_ren(1'b0);
		repeat (3) @(posedge aclk);
		pin(1'b0, 2);
		u_iic_bus_partner.set_ren(1'b1);
		cmd(iic_pkg::CMD_TAKE_CONTROL, 32'h0);
		pin(1'b1, 0);
		for (int k = 0; k < 2; k++) begin
			cap.delete();
			cmd(iic_pkg::CMD_GTL_SEQ, k == 0 ? 32'h8203 : 32'h0005);
			repeat (12) @(posedge aclk);
			chk(cap.size(), 6 - k);
			foreach (cap[j]) chk(32'(cap[j]), 32'(gexp[k][j]));
		end
		cmd(iic_pkg::CMD_SET_EOS, 32'h040a);
		for (int k = 0; k < 3; k++) begin
			cmd(iic_pkg::CMD_GO_STANDBY, k < 2 ? 32'h1 : 32'h0);
			pin(1'b0, 0);
			pin(k < 2, 3);
			if (k == 0) u_iic_bus_partner.send(8'h41, 1'b0, 1'b0);
			if (k == 0) pin(1'b0, 1);
			u_iic_bus_partner.send(k == 1 ? 8'h33 : 8'h0a, k != 0, 1'b0);
			repeat (20) @(posedge aclk);
			pin(k < 2, 1);
			cmd(iic_pkg::CMD_TAKE_CONTROL, 32'h0);
			pin(1'b1, 0);
			pin(1'b0, 1);
		end
		axw(iic_pkg::OFF_CMD, 32'h4, r);
		pin(1'b0, 0);
		cmd(iic_pkg::CMD_SET_PAD, 32'h9);
		axr(iic_pkg::OFF_STATUS, d, r);
		chk(32'(d[3]), 32'h0);
		axw(iic_pkg::OFF_CMD, 32'h14, r);
		axr(iic_pkg::OFF_ADDR, d, r);
		chk(32'(d[15:0]), 32'h4020);
		cmd(iic_pkg::CMD_SET_PAD, 32'h9);
		axw(iic_pkg::OFF_CMD, 32'h14, r);
		axr(iic_pkg::OFF_ADDR, d, r);
		chk(32'(d[15:0]), 32'h4020);
		summarize();
	end
endmodule
`default_nettype wire
